/* core/fram_ecc_cfg.svh */
// Constants of the double-bit error reporting block.
`ifndef FRAM_ECC_CFG_SVH
`define FRAM_ECC_CFG_SVH

// ----------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------
`define OP_UNIT_STATUS_READ 8'h19
`define OP_CLEAR_ECC 8'h1b
`define OP_CRC_COMPUTE 8'h5b
`define OP_CRC_SUSPEND 8'h75
`define OP_CRC_RESUME 8'h7a
`define OP_READ_ANY_REGISTER 8'h65

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define DUAL_BIT_DETECT_POS 4
`define UNIT_DUAL_ERROR_POS 3
`define UNIT_OFFSET_BITS 3
`define OPCODE_BITS 5'h08
`define ADDR_BITS 5'h18
`define STATUS_BITS 4'h8

// ----------------------------------------------------------------
// Reset values and counter limit
// ----------------------------------------------------------------
`define DUAL_ERROR_COUNT_RST 16'h0000
`define DUAL_ERROR_COUNT_MAX 16'hffff
`define FIRST_ERROR_ADDRESS_RST 32'h0000_0000

`endif

/* core/fram_ecc_pkg.sv */
// Types of the double-bit error reporting block.
package fram_ecc_pkg;
	typedef enum logic [2:0] {
		ST_OPCODE = 3'b000,
		ST_ADDR = 3'b001,
		ST_DUMMY = 3'b010,
		ST_DATA = 3'b011,
		ST_REST = 3'b100
	} link_state_t;
endpackage

/* core/fram_ecc_error_reporting.sv */
// Double-bit error reporting and ECC command handling of the serial memory.
`timescale 1ns/1ns
`default_nettype none
`include "fram_ecc_cfg.svh"
// Function
// - Double-bit read error sets status bit 4; clear-ECC command clears it.
// - A 16-bit volatile counter counts each double-bit error on array reads.
// - The counter stops at 0xFFFF and never wraps.
// - Deep power-down discards the counter; it reads 0x0000 after exit.
// - Any reset starts the counter again from 0x0000.
// - A 32-bit trap keeps the first failing unit address until cleared.
// - Deep power-down discards the trap; it reads zero after exit.
// - Counter and trap are driven only on output ports; the read-any-register opcode 65h is not decoded.
// - Opcode 19h is the unit status read, 1Bh is clear-ECC.
// - Status read takes a 3-byte address; low three bits are ignored.
// - After the address, wait latency-code dummy cycles, then shift eight status bits.
// - Host ends status read after eight bits; further clocks shift out zeros.
// - Status byte bit 3 marks a double-bit error in the unit; others zero.
// - Clear-ECC clears the flag, the trap and the counter together.
// - Clear-ECC runs without regard to the write enable latch.
// - The CRC engine covers only the main array, not sector or registers.
// - Opcodes 5Bh, 75h and 7Ah start, suspend and resume CRC.
// - ECC works on 8-byte units; single-bit errors are corrected silently.
// - Status register is driven on ecc_status_reg_o, not read through 65h, and cleared by resets or clear-ECC.
module fram_ecc_error_reporting (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_o,
	input wire logic [3:0] memory_latency_code_i,
	input wire logic dual_error_event_i,
	input wire logic [23:0] dual_error_unit_addr_i,
	input wire logic soft_reset_i,
	input wire logic deep_power_down_i,
	output logic [23:0] unit_query_addr_o,
	input wire logic unit_query_dual_error_i,
	output logic [7:0] ecc_status_reg_o,
	output logic [15:0] dual_error_count_o,
	output logic [31:0] first_error_address_o,
	output logic crc_compute_cmd_o,
	output logic crc_suspend_cmd_o,
	output logic crc_resume_cmd_o
);

	// ----------------------------------------------------------------
	// Link synchronisers
	// ----------------------------------------------------------------
	logic cs_m_q, cs_s_q, sck_m_q, sck_s_q, sck_p_q, mosi_m_q, mosi_s_q;
	logic sck_rise, sck_fall;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cs_m_q <= 1'b1;
			cs_s_q <= 1'b1;
			sck_m_q <= 1'b0;
			sck_s_q <= 1'b0;
			sck_p_q <= 1'b0;
			mosi_m_q <= 1'b0;
			mosi_s_q <= 1'b0;
		end else begin
			cs_m_q <= cs_n_i;
			cs_s_q <= cs_m_q;
			sck_m_q <= sck_i;
			sck_s_q <= sck_m_q;
			sck_p_q <= sck_s_q;
			mosi_m_q <= mosi_i;
			mosi_s_q <= mosi_m_q;
		end
	end

	assign sck_rise = sck_s_q & ~sck_p_q;
	assign sck_fall = ~sck_s_q & sck_p_q;

	// ----------------------------------------------------------------
	// Command decoder and status shifter
	// ----------------------------------------------------------------
	fram_ecc_pkg::link_state_t state_q, state_d;
	logic [23:0] shift_q, shift_d, query_q, query_d;
	logic [4:0] bit_cnt_q, bit_cnt_d;
	logic [3:0] out_cnt_q, out_cnt_d;
	logic [7:0] out_q, out_d;
	logic miso_q, miso_d, oe_q, oe_d;
	logic clear_q, clear_d, crc_compute_cmd_q, crc_compute_cmd_d, crcs_q, crcs_d, crcr_q, crcr_d;
	logic [23:0] shift_in;
	logic [7:0] status_byte;

	assign shift_in = {shift_q[22:0], mosi_s_q};
	assign status_byte = {4'h0, unit_query_dual_error_i, 3'h0};

	always_comb begin
		state_d = state_q;
		shift_d = shift_q;
		query_d = query_q;
		bit_cnt_d = bit_cnt_q;
		out_cnt_d = out_cnt_q;
		out_d = out_q;
		miso_d = miso_q;
		oe_d = oe_q;
		clear_d = 1'b0;
		crc_compute_cmd_d = 1'b0;
		crcs_d = 1'b0;
		crcr_d = 1'b0;
		if (cs_s_q) begin
			state_d = fram_ecc_pkg::ST_OPCODE;
			bit_cnt_d = 5'h00;
			out_cnt_d = 4'h0;
			miso_d = 1'b0;
			oe_d = 1'b0;
		end else if (sck_rise) begin
			case (state_q)
				fram_ecc_pkg::ST_OPCODE: begin
					shift_d = shift_in;
					bit_cnt_d = bit_cnt_q + 5'h01;
					if (bit_cnt_d == `OPCODE_BITS) begin
						bit_cnt_d = 5'h00;
						state_d = fram_ecc_pkg::ST_REST;
						case (shift_in[7:0])
							`OP_UNIT_STATUS_READ: state_d = fram_ecc_pkg::ST_ADDR;
							`OP_CLEAR_ECC: clear_d = 1'b1;
							`OP_CRC_COMPUTE: crc_compute_cmd_d = 1'b1;
							`OP_CRC_SUSPEND: crcs_d = 1'b1;
							`OP_CRC_RESUME: crcr_d = 1'b1;
							default: state_d = fram_ecc_pkg::ST_REST;
						endcase
					end
				end
				fram_ecc_pkg::ST_ADDR: begin
					shift_d = shift_in;
					bit_cnt_d = bit_cnt_q + 5'h01;
					if (bit_cnt_d == `ADDR_BITS) begin
						bit_cnt_d = 5'h00;
						query_d = {shift_in[23:`UNIT_OFFSET_BITS], 3'h0};
						if (memory_latency_code_i == 4'h0) begin
							state_d = fram_ecc_pkg::ST_DATA;
						end else begin
							state_d = fram_ecc_pkg::ST_DUMMY;
						end
					end
				end
				fram_ecc_pkg::ST_DUMMY: begin
					bit_cnt_d = bit_cnt_q + 5'h01;
					if (bit_cnt_d[3:0] == memory_latency_code_i) begin
						state_d = fram_ecc_pkg::ST_DATA;
					end
				end
				default: state_d = state_q;
			endcase
		end else if (sck_fall && state_q == fram_ecc_pkg::ST_DATA) begin
			oe_d = 1'b1;
			if (out_cnt_q == 4'h0) begin
				miso_d = status_byte[7];
				out_d = {status_byte[6:0], 1'b0};
			end else begin
				miso_d = out_q[7];
				out_d = {out_q[6:0], 1'b0};
			end
			if (out_cnt_q != `STATUS_BITS) begin
				out_cnt_d = out_cnt_q + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= fram_ecc_pkg::ST_OPCODE;
			shift_q <= 24'h00_0000;
			query_q <= 24'h00_0000;
			bit_cnt_q <= 5'h00;
			out_cnt_q <= 4'h0;
			out_q <= 8'h00;
			miso_q <= 1'b0;
			oe_q <= 1'b0;
			clear_q <= 1'b0;
			crc_compute_cmd_q <= 1'b0;
			crcs_q <= 1'b0;
			crcr_q <= 1'b0;
		end else begin
			state_q <= state_d;
			shift_q <= shift_d;
			query_q <= query_d;
			bit_cnt_q <= bit_cnt_d;
			out_cnt_q <= out_cnt_d;
			out_q <= out_d;
			miso_q <= miso_d;
			oe_q <= oe_d;
			clear_q <= clear_d;
			crc_compute_cmd_q <= crc_compute_cmd_d;
			crcs_q <= crcs_d;
			crcr_q <= crcr_d;
		end
	end

	// ----------------------------------------------------------------
	// Error flag, counter and address trap
	// ----------------------------------------------------------------
	logic flag_q, flag_d;
	logic [15:0] count_q, count_d;
	logic [31:0] trap_q, trap_d;
	logic event_ok;

	assign event_ok = dual_error_event_i & ~deep_power_down_i & ~soft_reset_i;

	always_comb begin
		flag_d = flag_q;
		count_d = count_q;
		trap_d = trap_q;
		if (deep_power_down_i) begin
			flag_d = 1'b0;
			count_d = `DUAL_ERROR_COUNT_RST;
			trap_d = `FIRST_ERROR_ADDRESS_RST;
		end else if (soft_reset_i) begin
			flag_d = 1'b0;
			count_d = `DUAL_ERROR_COUNT_RST;
			trap_d = `FIRST_ERROR_ADDRESS_RST;
		end else begin
			if (clear_q) begin
				flag_d = 1'b0;
				count_d = `DUAL_ERROR_COUNT_RST;
				trap_d = `FIRST_ERROR_ADDRESS_RST;
			end
			if (event_ok) begin
				flag_d = 1'b1;
				if (count_d != `DUAL_ERROR_COUNT_MAX) begin
					count_d = count_d + 16'h0001;
				end
				if (!flag_q || clear_q) begin
					trap_d = {8'h00, dual_error_unit_addr_i};
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flag_q <= 1'b0;
			count_q <= `DUAL_ERROR_COUNT_RST;
			trap_q <= `FIRST_ERROR_ADDRESS_RST;
		end else begin
			flag_q <= flag_d;
			count_q <= count_d;
			trap_q <= trap_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign miso_o = miso_q;
	assign miso_oe_o = oe_q;
	assign unit_query_addr_o = query_q;
	assign ecc_status_reg_o = {3'h0, flag_q, 4'h0};
	assign dual_error_count_o = count_q;
	assign first_error_address_o = trap_q;
	assign crc_compute_cmd_o = crc_compute_cmd_q;
	assign crc_suspend_cmd_o = crcs_q;
	assign crc_resume_cmd_o = crcr_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_quiet;
		!deep_power_down_i && !soft_reset_i && !clear_q;
	endsequence

	sequence s_first_hit;
		s_quiet ##0 event_ok && !flag_q;
	endsequence

	property p_flag_set;
		event_ok |=> ecc_status_reg_o[`DUAL_BIT_DETECT_POS];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set");

	property p_count_inc;
		s_quiet ##0 event_ok && count_q != 16'hffff |=> count_q == $past(count_q) + 16'h0001;
	endproperty
	a_count_inc: assert property (p_count_inc) else $error("count not advanced");

	property p_count_sat;
		s_quiet ##0 count_q == 16'hffff |=> count_q == 16'hffff;
	endproperty
	a_count_sat: assert property (p_count_sat) else $error("count wrapped");

	property p_dpd_clear;
		deep_power_down_i |=> count_q == 16'h0000 && trap_q == 32'h0;
	endproperty
	a_dpd_clear: assert property (p_dpd_clear) else $error("power-down kept data");

	property p_reset_count;
		soft_reset_i && !deep_power_down_i |=> count_q == 16'h0000 && !flag_q;
	endproperty
	a_reset_count: assert property (p_reset_count) else $error("reset kept count");

	property p_first_capture;
		s_first_hit |=> trap_q == {8'h00, $past(dual_error_unit_addr_i)} && flag_q;
	endproperty
	a_first_capture: assert property (p_first_capture) else $error("trap missed");

	property p_trap_hold;
		s_quiet ##0 flag_q |=> $stable(trap_q);
	endproperty
	a_trap_hold: assert property (p_trap_hold) else $error("trap overwritten");

	property p_clear_all;
		clear_q && !event_ok |=> !flag_q && count_q == 16'h0000 && trap_q == 32'h0;
	endproperty
	a_clear_all: assert property (p_clear_all) else $error("clear incomplete");

	property p_drive_in_frame;
		miso_oe_o |-> !cs_s_q || $past(!cs_s_q);
	endproperty
	a_drive_in_frame: assert property (p_drive_in_frame) else $error("drive outside frame");

	property p_status_shape;
		state_q == fram_ecc_pkg::ST_DATA && out_cnt_q == 4'h1 |->
			!miso_q && out_q[7:5] == 3'h0 && out_q[3:1] == 3'h0;
	endproperty
	a_status_shape: assert property (p_status_shape) else $error("status bits set");

endmodule
`default_nettype wire

/* bench/spi_host_model.sv */
// Serial host model that drives the command link of the error reporting block.
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
	input wire logic clk_i,
	output logic cs_n_o,
	output logic sck_o,
	output logic mosi_o,
	input wire logic miso_i
);
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		mosi_o = 1'b0;
	end
	task automatic half();
		repeat (10) @(negedge clk_i);
	endtask
	// Mode 0 bit: data is set while the clock is low and read at the rise.
	task automatic xfer(input logic d, output logic q);
		mosi_o = d;
		half();
		sck_o = 1'b1;
		q = miso_i;
		half();
		sck_o = 1'b0;
	endtask
	task automatic run(input logic [7:0] op, input logic [23:0] a, input int lat,
		input logic rdb, output logic [7:0] rd);
		logic q;
		rd = 8'h00;
		cs_n_o = 1'b0;
		for (int i = 7; i >= 0; i--) xfer(op[i], q);
		if (rdb) begin
			for (int i = 23; i >= 0; i--) xfer(a[i], q);
			for (int i = 0; i < lat; i++) xfer(i[0], q);
			for (int i = 7; i >= 0; i--) begin
				xfer(1'b0, q);
				rd[i] = q;
			end
		end
		half();
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		repeat (20) @(negedge clk_i);
	endtask
endmodule
`default_nettype wire

/* bench/fram_ecc_error_reporting_tb.sv */
// Self-checking bench of the double-bit error reporting block.
`timescale 1ns/1ns
`default_nettype none
`include "fram_ecc_cfg.svh"
module fram_ecc_error_reporting_tb;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic cs_n, sck, mosi, miso, miso_oe;
	logic [3:0] lat = 4'h0;
	logic ev = 1'b0;
	logic [23:0] ev_addr = 24'h000000;
	logic soft_rst = 1'b0;
	logic deep_power_down = 1'b0;
	logic [23:0] q_addr, a0, a;
	logic [7:0] esr, rd;
	logic [15:0] cnt;
	logic [31:0] trap;
	wire [2:0] crc_p;
	logic [2:0] crc_seen = 3'h0;
	logic crc_clr = 1'b0;
	logic [7:0] ops [4] = '{8'h5b, 8'h75, 8'h7a, 8'h65};
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	int n;
	always #2 clk_i = ~clk_i;
	function automatic logic unit_bad(input logic [23:0] x);
		return x[3] ^ x[11] ^ x[20];
	endfunction
	fram_ecc_error_reporting dut (.clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n), .sck_i(sck),
		.mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .memory_latency_code_i(lat),
		.dual_error_event_i(ev), .dual_error_unit_addr_i(ev_addr), .soft_reset_i(soft_rst),
		.deep_power_down_i(deep_power_down), .unit_query_addr_o(q_addr),
		.unit_query_dual_error_i(unit_bad(q_addr)), .ecc_status_reg_o(esr),
		.dual_error_count_o(cnt), .first_error_address_o(trap), .crc_compute_cmd_o(crc_p[0]),
		.crc_suspend_cmd_o(crc_p[1]), .crc_resume_cmd_o(crc_p[2]));
	spi_host_model host (.clk_i(clk_i), .cs_n_o(cs_n), .sck_o(sck), .mosi_o(mosi),
		.miso_i(miso));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask
	task automatic burst(input int k, input logic [23:0] first);
		ev = 1'b1;
		ev_addr = first;
		for (int i = 0; i < k; i++) begin
			@(negedge clk_i);
			ev_addr = 24'($urandom) & 24'hfffff8;
		end
		ev = 1'b0;
		@(negedge clk_i);
	endtask
	task automatic zero_all(input string m);
		check(esr, 32'h0, m);
		check(cnt, 32'h0, m);
		check(trap, 32'h0, m);
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (crc_clr) begin
			crc_seen <= 3'h0;
		end else begin
			crc_seen <= crc_seen | crc_p;
		end
	end
	task automatic run_tests();
		repeat (12) @(negedge clk_i);
		nrst_i = 1'b1;
		repeat (4) @(negedge clk_i);
		zero_all("reset");
		$display("test reset done");
		a0 = 24'($urandom) & 24'hfffff8;
		n = 2 + $urandom_range(6);
		burst(1, a0);
		check(esr, 32'h10, "flag");
		check(cnt, 32'h1, "count");
		check(trap, {8'h00, a0}, "trap");
		burst(n - 1, 24'($urandom) & 24'hfffff8);
		check(cnt, n, "count");
		check(trap, {8'h00, a0}, "trap kept");
		host.run(`OP_CLEAR_ECC, 24'h0, 0, 1'b0, rd);
		zero_all("clear");
		$display("test events and clear done");
		for (int i = 0; i < 4; i++) begin
			a = (i == 0) ? 24'h000008 : (i == 1) ? 24'h000007 : 24'($urandom);
			lat = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom);
			host.run(`OP_UNIT_STATUS_READ, a, int'(lat), 1'b1, rd);
			check(rd, {4'h0, unit_bad(a & 24'hfffff8), 3'h0}, "status");
			check(q_addr, a & 24'hfffff8, "unit addr");
			check(miso_oe, 1'b0, "oe");
		end
		$display("test status read done");
		burst(1, 24'h000008);
		for (int k = 0; k < 4; k++) begin
			crc_clr = 1'b1;
			@(negedge clk_i);
			crc_clr = 1'b0;
			host.run(ops[k], 24'h0, 0, 1'b0, rd);
			check(crc_seen, (k < 3) ? 3'(1 << k) : 3'h0, "crc op");
		end
		check(cnt, 32'h1, "unknown op");
		$display("test opcodes done");
		burst(3, 24'h000010);
		deep_power_down = 1'b1;
		burst(2, 24'h000018);
		zero_all("dpd");
		deep_power_down = 1'b0;
		@(negedge clk_i);
		zero_all("dpd exit");
		burst(2, 24'h000020);
		soft_rst = 1'b1;
		@(negedge clk_i);
		soft_rst = 1'b0;
		@(negedge clk_i);
		zero_all("soft reset");
		$display("test power down and reset done");
		burst(65540, 24'h000028);
		check(cnt, 32'hffff, "saturate");
		$display("test saturation done");
	endtask
	initial begin
		void'($urandom(82));
		fork
			run_tests();
			begin
				wait (cyc >= 90000);
				n_fail++;
				$display("[ERR] %0t timeout", $time);
			end
		join_any
		stop_test();
	end
endmodule
`default_nettype wire
